// file: verilog/adcs_map.vh
`ifndef ADCS_MAP_VH
`define ADCS_MAP_VH
// register byte offsets
`define ADCS_OFF_MODE 8'h00
`define ADCS_OFF_RESULT 8'h04
`define ADCS_OFF_PINCNT 8'h08
`define ADCS_OFF_STATUS 8'h0c
`define ADCS_OFF_MASK 8'h10
// mode register fields
`define ADCS_MODE_RUN 7
`define ADCS_MODE_TRIG 6
`define ADCS_CH_HI 3
`define ADCS_CH_LO 1
`define ADCS_MODE_RST 8'h00
`define ADCS_PINCNT_RST 4'h0
`define ADCS_PINCNT_MAX 4'h8
// status bit of the completion flag
`define ADCS_ST_DONE 0
`define ADCS_RESP_OKAY 2'b00
`define ADCS_RESP_SLVERR 2'b10
`endif

// file: verilog/adcs_sar_core.v
`timescale 1ns/1ns
`include "adcs_map.vh"
// successive approximation over WIDTH bits, msb first
module adcs_sar_core #(
	parameter WIDTH = 8,
	parameter SAMPLE_CYCLES = 4
) (
	input wire mclk,
	input wire rst,
	input wire start,
	input wire abort,
	input wire hold,
	input wire compGe,
	output reg [WIDTH-1:0] trial,
	output reg busy,
	output reg sampling,
	output reg done,
	output reg [WIDTH-1:0] result
);
	reg [WIDTH-1:0] bitPtr;
	reg [7:0] sampleCnt;
	always @(posedge mclk) begin
		// a stopped clock must not lose a completion that is still waiting to be seen
		done <= done && hold && !rst;
		if (rst) begin
			trial <= {WIDTH{1'b0}};
			bitPtr <= {WIDTH{1'b0}};
			busy <= 1'b0;
			sampling <= 1'b0;
			sampleCnt <= 8'h00;
			result <= {WIDTH{1'b0}};
		end else if (hold) begin
			busy <= busy;
		end else if (abort) begin
			busy <= 1'b0;
			sampling <= 1'b0;
			trial <= {WIDTH{1'b0}};
		end else if (start) begin
			busy <= 1'b1;
			sampling <= 1'b1;
			sampleCnt <= SAMPLE_CYCLES[7:0];
			trial <= {WIDTH{1'b0}};
			bitPtr <= {1'b1, {(WIDTH-1){1'b0}}};
		end else if (busy && sampling) begin
			if (sampleCnt == 8'h01) begin
				sampling <= 1'b0;
				trial <= bitPtr;
			end
			sampleCnt <= sampleCnt - 8'h01;
		end else if (busy) begin
			// keep trial bit when input is at or above the tap
			if (bitPtr == {{(WIDTH-1){1'b0}}, 1'b1}) begin
				result <= compGe ? trial : (trial & ~bitPtr);
				busy <= 1'b0;
				done <= 1'b1;
				trial <= {WIDTH{1'b0}};
			end else begin
				trial <= (compGe ? trial : (trial & ~bitPtr)) | (bitPtr >> 1);
				bitPtr <= bitPtr >> 1;
			end
		end
	end
endmodule // adcs_sar_core

// file: verilog/adcs_start_sequencer.v
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "adcs_map.vh"
// What this block does
// - trigger select and run both set: wait armed until external trigger
// - on trigger convert channel chosen by mode bits 1-3
// - each completion stores result and raises completion interrupt
// - trigger mode: one conversion per trigger, then wait again
// - trigger mode: rewrite with run set aborts, returns armed
// - rewrite with run clear stops conversion immediately
// - software mode with run set starts converting at once
// - software mode restarts after each completion until rewrite
// - software mode: rewrite with run set restarts with new settings
// - mode writes never clear the completion flag
// - a completion just before a rewrite may leave flag and result set
// - runs on main clock; halts when clock stopped or subclock halt
// - eight-bit successive approximation, bit 7 down to bit 0
// - four-bit pin count, reset zero, values 0..8 only
module adcs_start_sequencer #(
	parameter WIDTH = 8,
	parameter SAMPLE_CYCLES = 4
) (
	input wire mclk,
	input wire rst,
	input wire clkHalt,
	input wire extTriggerIn,
	input wire compGe,
	output wire [WIDTH-1:0] dacTap,
	output reg [2:0] muxSel,
	output reg [7:0] analogPinEnable,
	output reg convBusy,
	output wire convDoneIrq,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);
	localparam ST_IDLE = 3'b001;
	localparam ST_ARMED = 3'b010;
	localparam ST_CONV = 3'b100;

	reg [7:0] convModeReg;
	reg [3:0] analogPinCountReg;
	reg [WIDTH-1:0] convResultReg;
	reg convDoneFlag;
	reg convDoneMask;
	reg [2:0] state;
	reg [2:0] next_state;
	reg trigMode;
	reg trigPrev;
	reg awHeld;
	reg wHeld;
	reg [7:0] awAddr;
	reg [31:0] wData;
	reg [3:0] wStrb;

	wire sarBusy;
	wire sarSampling;
	wire sarDone;
	wire [WIDTH-1:0] sarResult;
	wire trigEdge;
	wire wrFire;
	wire modeWr;
	wire runBit;
	wire trigBit;
	reg sarStart;
	reg sarAbort;

	// write address and data may arrive in either order; hold each until both present
	assign s_axi_awready = !awHeld && !s_axi_bvalid;
	assign s_axi_wready = !wHeld && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	wire awNow = awHeld || (s_axi_awvalid && s_axi_awready);
	wire wNow = wHeld || (s_axi_wvalid && s_axi_wready);
	wire [7:0] curAw = awHeld ? awAddr : s_axi_awaddr;
	wire [31:0] curW = wHeld ? wData : s_axi_wdata;
	wire [3:0] curStrb = wHeld ? wStrb : s_axi_wstrb;
	assign wrFire = awNow && wNow && !s_axi_bvalid;
	assign modeWr = wrFire && (curAw == `ADCS_OFF_MODE) && curStrb[0];
	assign runBit = curW[`ADCS_MODE_RUN];
	assign trigBit = curW[`ADCS_MODE_TRIG];

	// gated clock model: halt freezes sequencer, SAR core and trigger detect; register writes, muxSel included, still land
	wire active = !clkHalt;
	assign trigEdge = active && extTriggerIn && !trigPrev;

	always @(posedge mclk) begin
		if (rst) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddr <= 8'h00;
			wData <= 32'h00000000;
			wStrb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ADCS_RESP_OKAY;
		end else begin
			if (wrFire) begin
				awHeld <= 1'b0;
				wHeld <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (curAw)
					`ADCS_OFF_MODE, `ADCS_OFF_RESULT, `ADCS_OFF_PINCNT,
					`ADCS_OFF_STATUS, `ADCS_OFF_MASK: s_axi_bresp <= `ADCS_RESP_OKAY;
					default: s_axi_bresp <= `ADCS_RESP_SLVERR;
				endcase
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					awHeld <= 1'b1;
					awAddr <= s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					wHeld <= 1'b1;
					wData <= s_axi_wdata;
					wStrb <= s_axi_wstrb;
				end
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// registers
	always @(posedge mclk) begin
		if (rst) begin
			convModeReg <= `ADCS_MODE_RST;
			analogPinCountReg <= `ADCS_PINCNT_RST;
			convDoneMask <= 1'b0;
			convResultReg <= {WIDTH{1'b0}};
		end else begin
			if (modeWr)
				convModeReg <= curW[7:0];
			// prohibited pin counts are ignored
			if (wrFire && curAw == `ADCS_OFF_PINCNT && curStrb[0] &&
				curW[3:0] <= `ADCS_PINCNT_MAX)
				analogPinCountReg <= curW[3:0];
			if (wrFire && curAw == `ADCS_OFF_MASK && curStrb[0])
				convDoneMask <= curW[`ADCS_ST_DONE];
			// a completion racing a rewrite still lands
			if (sarDone)
				convResultReg <= sarResult;
		end
	end

	// flag: set wins over write-one-to-clear; mode writes do not touch it
	always @(posedge mclk) begin
		if (rst)
			convDoneFlag <= 1'b0;
		else if (sarDone)
			convDoneFlag <= 1'b1;
		else if (wrFire && curAw == `ADCS_OFF_STATUS && curStrb[0] &&
			curW[`ADCS_ST_DONE])
			convDoneFlag <= 1'b0;
	end
	assign convDoneIrq = convDoneFlag && convDoneMask;

	// thermometer of analog-enabled inputs, counted from input 0
	integer i;
	always @(posedge mclk) begin
		if (rst)
			analogPinEnable <= 8'h00;
		else
			for (i = 0; i < 8; i = i + 1)
				analogPinEnable[i] <= (i < analogPinCountReg);
	end

	// sequencer
	always @* begin
		next_state = state;
		sarStart = 1'b0;
		sarAbort = 1'b0;
		if (!active) begin
			next_state = state;
		end else if (modeWr) begin
			sarAbort = 1'b1;
			if (!runBit)
				next_state = ST_IDLE;
			else if (trigBit)
				next_state = ST_ARMED;
			else begin
				next_state = ST_CONV;
				sarStart = 1'b1;
			end
		end else begin
			case (state)
				ST_IDLE: next_state = ST_IDLE;
				ST_ARMED: begin
					if (trigEdge) begin
						next_state = ST_CONV;
						sarStart = 1'b1;
					end
				end
				ST_CONV: begin
					if (sarDone) begin
						if (trigMode)
							next_state = ST_ARMED;
						else
							sarStart = 1'b1;
					end
				end
				default: next_state = ST_IDLE;
			endcase
		end
	end

	always @(posedge mclk) begin
		if (rst) begin
			state <= ST_IDLE;
			trigMode <= 1'b0;
			muxSel <= 3'h0;
			trigPrev <= 1'b0;
			convBusy <= 1'b0;
		end else begin
			if (active)
				trigPrev <= extTriggerIn;
			state <= next_state;
			convBusy <= (next_state == ST_CONV);
			if (modeWr) begin
				trigMode <= trigBit;
				muxSel <= curW[`ADCS_CH_HI:`ADCS_CH_LO];
			end
		end
	end

	wire [WIDTH-1:0] trial_w;
	assign dacTap = sarBusy ? trial_w : {WIDTH{1'b0}};

	adcs_sar_core #(
		.WIDTH(WIDTH),
		.SAMPLE_CYCLES(SAMPLE_CYCLES)
	) uSar (
		.mclk(mclk),
		.rst(rst),
		.start(sarStart),
		.abort(sarAbort && !sarStart),
		.hold(!active),
		.compGe(compGe && active),
		.trial(trial_w),
		.busy(sarBusy),
		.sampling(sarSampling),
		.done(sarDone),
		.result(sarResult)
	);

	// reads
	always @(posedge mclk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `ADCS_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `ADCS_RESP_OKAY;
				case (s_axi_araddr)
					`ADCS_OFF_MODE: s_axi_rdata <= {24'h000000, convModeReg};
					`ADCS_OFF_RESULT: s_axi_rdata <= {{(32-WIDTH){1'b0}}, convResultReg};
					`ADCS_OFF_PINCNT: s_axi_rdata <= {28'h0000000, analogPinCountReg};
					`ADCS_OFF_STATUS: s_axi_rdata <= {30'h00000000, convBusy, convDoneFlag};
					`ADCS_OFF_MASK: s_axi_rdata <= {31'h00000000, convDoneMask};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= `ADCS_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule // adcs_start_sequencer

// file: verification/adcs_analog_src.sv
`timescale 1ns/1ns
module adcs_analog_src (
	input wire [2:0] muxSel,
	input wire [7:0] dacTap,
	input wire [63:0] vin,
	output wire compGe
);
	// the analog pins are never read as digital inputs here
	// ideal comparator: the selected input against the trial tap
	assign compGe = vin[{muxSel, 3'h0}+:8] >= dacTap;
endmodule // adcs_analog_src

// file: verification/adcs_seq_chk.sv
`timescale 1ns/1ns
module adcs_seq_chk #(
	parameter WIDTH = 8
) (
	input wire mclk,
	input wire rst,
	input wire clkHalt,
	input wire [WIDTH-1:0] dacTap,
	input wire convBusy,
	input wire convDoneIrq,
	input wire s_axi_awready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	halt_freeze_a: assert property (clkHalt |=> $stable(dacTap) && $stable(convBusy))
		else $error("converter moved while halted");
	msb_first_a: assert property ($past(dacTap) == 0 && dacTap != 0 |-> dacTap == 8'h80)
		else $error("first trial is not bit 7");
	next_trial_a: assert property ($past(dacTap) == 8'h80 && !$past(clkHalt) && dacTap != 0
		|-> dacTap[6] && dacTap[5:0] == 0) else $error("second trial is not bit 6");
	flag_kept_a: assert property ($fell(convDoneIrq) |-> ##[0:1] s_axi_bvalid)
		else $error("completion flag dropped without a write");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response withdrawn");
	rresp_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read data withdrawn");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write taken while response pending");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	cover property ($rose(convBusy));
	cover property ($rose(convDoneIrq));
	cover property (clkHalt && convBusy);
endmodule // adcs_seq_chk
bind adcs_start_sequencer adcs_seq_chk #(.WIDTH(WIDTH)) chk (.*);

// file: verification/adcs_start_sequencer_tb.sv
`timescale 1ns/1ns
`include "adcs_map.vh"
module adcs_start_sequencer_tb;
	reg mclk = 1'h0;
	reg rst = 1'h1;
	reg clkHalt = 1'h0;
	reg extTriggerIn = 1'h0;
	reg [7:0] s_axi_awaddr = 8'h0;
	reg [7:0] s_axi_araddr = 8'h0;
	reg [31:0] s_axi_wdata = 32'h0;
	reg [3:0] s_axi_wstrb = 4'hf;
	reg s_axi_awvalid = 1'h0;
	reg s_axi_wvalid = 1'h0;
	reg s_axi_bready = 1'h0;
	reg s_axi_arvalid = 1'h0;
	reg s_axi_rready = 1'h0;
	wire compGe, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire convBusy, convDoneIrq;
	wire [7:0] dacTap, analogPinEnable;
	wire [2:0] muxSel;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	reg [63:0] vin = 64'h0;
	reg [31:0] rd;
	reg [1:0] rr;
	reg [2:0] ch;
	integer seed = 91, num_errors = 0, total_checks = 0, cyc = 0, i, n;
	adcs_start_sequencer DUT (.*);
	adcs_analog_src src (.muxSel(muxSel), .dacTap(dacTap), .vin(vin), .compGe(compGe));
	initial begin
		forever #5 mclk = ~mclk;
	end
	task final_report;
		begin
			if (num_errors == 0 && total_checks > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors = num_errors + 1;
			final_report;
		end
	end
	task chk(input [31:0] e, input [31:0] g);
		begin
			total_checks = total_checks + 1;
			if (g !== e) begin
				num_errors = num_errors + 1;
				$display("MISMATCH %0t exp %h got %h", $time, e, g);
			end
		end
	endtask
	task tick(input integer k);
		begin
			repeat (k) @(posedge mclk);
		end
	endtask
	// ready seen at the falling edge is what the next rising edge samples
	task wr(input [7:0] a, input [31:0] d);
		reg pa, pw;
		begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'h1;
			s_axi_wvalid <= 1'h1;
			pa = 1;
			pw = 1;
			while (pa || pw) begin
				@(negedge mclk);
				pa = pa && !s_axi_awready;
				pw = pw && !s_axi_wready;
				@(posedge mclk);
				s_axi_awvalid <= pa;
				s_axi_wvalid <= pw;
			end
			s_axi_bready <= 1'h1;
			pa = 1;
			while (pa) begin
				@(negedge mclk);
				pa = !s_axi_bvalid;
				rr = s_axi_bresp;
				@(posedge mclk);
			end
			s_axi_bready <= 1'h0;
			chk((a > `ADCS_OFF_MASK || a[1:0] != 2'h0) ? `ADCS_RESP_SLVERR : `ADCS_RESP_OKAY, rr);
		end
	endtask
	task rdr(input [7:0] a, input [1:0] er);
		reg p;
		begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'h1;
			p = 1;
			while (p) begin
				@(negedge mclk);
				p = !s_axi_arready;
				@(posedge mclk);
			end
			s_axi_arvalid <= 1'h0;
			s_axi_rready <= 1'h1;
			p = 1;
			while (p) begin
				@(negedge mclk);
				p = !s_axi_rvalid;
				rd = s_axi_rdata;
				rr = s_axi_rresp;
				@(posedge mclk);
			end
			s_axi_rready <= 1'h0;
			chk(er, rr);
		end
	endtask
	task waitIrq;
		begin
			n = 0;
			while (convDoneIrq !== 1'h1 && n < 200) begin
				@(negedge mclk);
				n = n + 1;
			end
			@(posedge mclk);
			chk(1, convDoneIrq);
		end
	endtask
	task trig;
		begin
			extTriggerIn <= 1'h1;
			tick(2);
			extTriggerIn <= 1'h0;
		end
	endtask
	function [7:0] sarExp(input [7:0] v);
		integer b;
		begin
			sarExp = 8'h0;
			for (b = 7; b >= 0; b = b - 1)
				if (v >= (sarExp | (8'h1 << b))) sarExp = sarExp | (8'h1 << b);
		end
	endfunction
	task result;
		begin
			rdr(`ADCS_OFF_RESULT, 2'h0);
			chk(sarExp(vin[{ch, 3'h0}+:8]), rd);
		end
	endtask
	initial begin
		tick(4);
		rst <= 1'h0;
		tick(1);
		for (i = 0; i < 5; i = i + 1) begin
			if (i != 1) rdr(i * 4, 2'h0);
			if (i != 1) chk(0, rd);
		end
		rdr(8'h14, `ADCS_RESP_SLVERR);
		chk(0, rd);
		wr(8'h14, 0);
		for (i = 0; i < 10; i = i + 1) begin
			wr(`ADCS_OFF_PINCNT, i);
			n = i > 8 ? 8 : i;
			tick(2);
			rdr(`ADCS_OFF_PINCNT, 2'h0);
			chk(n, rd);
			chk((32'h1 << n) - 1, analogPinEnable);
		end
		vin <= {$random(seed), $random(seed)};
		ch = $random(seed);
		wr(`ADCS_OFF_MASK, 1);
		wr(`ADCS_OFF_MODE, 8'h80 | {ch, 1'h0});
		chk(ch, muxSel);
		waitIrq;
		result;
		wr(`ADCS_OFF_STATUS, 1);
		waitIrq;
		ch = ch + 3'h3;
		wr(`ADCS_OFF_MODE, 8'h80 | {ch, 1'h0});
		chk(1, convDoneIrq);
		wr(`ADCS_OFF_STATUS, 1);
		waitIrq;
		result;
		clkHalt <= 1'h1;
		tick(30);
		clkHalt <= 1'h0;
		wr(`ADCS_OFF_MODE, 0);
		chk(0, convBusy);
		wr(`ADCS_OFF_STATUS, 1);
		tick(40);
		chk(0, convDoneIrq);
		wr(`ADCS_OFF_MODE, 8'hc0 | {ch, 1'h0});
		tick(40);
		chk(0, convDoneIrq | convBusy);
		for (i = 0; i < 3; i = i + 1) begin
			vin <= {$random(seed), $random(seed)};
			trig;
			if (i == 2) tick(6);
			if (i == 2) wr(`ADCS_OFF_MODE, 8'hc0 | {ch, 1'h0});
			if (i == 2) chk(0, convBusy);
			if (i < 2) waitIrq;
			if (i < 2) result;
			wr(`ADCS_OFF_STATUS, 1);
			tick(40);
			chk(0, convDoneIrq);
		end
		trig;
		waitIrq;
		result;
		final_report;
	end
endmodule // adcs_start_sequencer_tb
